// File: include/wdit_pkg.sv
// Package: register map, field layout, reset values and timing counts of the supervisory timer
package wdit_pkg;
	// ----------------------------------------
	// Register addresses (byte addresses)
	// ----------------------------------------
	localparam logic [31:0] WDIT_CTRL_ADDR      = 32'hffff8610; // Control write/read, count write
	localparam logic [31:0] WDIT_COUNT_ADDR     = 32'hffff8611; // Count read
	localparam logic [31:0] WDIT_RSTCTL_WADDR   = 32'hffff8612; // Reset-control write
	localparam logic [31:0] WDIT_RSTCTL_RADDR   = 32'hffff8613; // Reset-control read
	// ----------------------------------------
	// Keys and reset values
	// ----------------------------------------
	localparam logic [7:0]  WDIT_KEY_COUNT      = 8'h5a;
	localparam logic [7:0]  WDIT_KEY_CTRL       = 8'ha5;
	localparam logic [7:0]  WDIT_CTRL_RESET     = 8'h18;
	localparam logic [7:0]  WDIT_COUNT_RESET    = 8'h00;
	localparam logic [7:0]  WDIT_RSTCTL_RESET   = 8'h1f;
	localparam logic [7:0]  WDIT_CTRL_ONES      = 8'h18; // Bits 4 and 3 read as one
	localparam logic [7:0]  WDIT_RSTCTL_ONES    = 8'h1f; // Bits 4 to 0 read as one
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int          WDIT_FLAG_BIT       = 7;
	localparam int          WDIT_MODE_BIT       = 6;
	localparam int          WDIT_ENABLE_BIT     = 5;
	localparam int          WDIT_RSTSEL_BIT     = 5;
	localparam int          WDIT_RSTEN_BIT      = 6;
	// ----------------------------------------
	// Bus access sizes
	// ----------------------------------------
	localparam logic [1:0]  WDIT_SIZE_BYTE      = 2'h0;
	localparam logic [1:0]  WDIT_SIZE_WORD      = 2'h1;
	localparam logic [1:0]  WDIT_SIZE_LONG      = 2'h2;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int          WDIT_SYS_MHZ        = 200;
	localparam int          WDIT_RST_CYCLES     = 512;  // Internal reset length in system clocks
	localparam int          WDIT_PRESCALE_W     = 13;   // Widest division is 8192
	// Prescaler tap per clock-select code: divide by 2,64,128,256,512,1024,4096,8192
	localparam logic [3:0]  WDIT_TAP0           = 4'h0;
	localparam logic [3:0]  WDIT_TAP1           = 4'h5;
	localparam logic [3:0]  WDIT_TAP2           = 4'h6;
	localparam logic [3:0]  WDIT_TAP3           = 4'h7;
	localparam logic [3:0]  WDIT_TAP4           = 4'h8;
	localparam logic [3:0]  WDIT_TAP5           = 4'h9;
	localparam logic [3:0]  WDIT_TAP6           = 4'hb;
	localparam logic [3:0]  WDIT_TAP7           = 4'hc;
	typedef enum logic [0:0]
	{
		WDIT_RST_IDLE  = 1'b0,
		WDIT_RST_PULSE = 1'b1
	} wdit_rst_state_t;
endpackage

// File: logic/wdit_prescaler.sv
// Free-running prescaler that yields the selected counting tick
`timescale 1ns/1ps
module wdit_prescaler
#(
	parameter int WIDTH = 13
)
(
	// Clock and reset
	input  wire logic              core_clk_i,
	input  wire logic              rst_i,
	// Select and tick
	input  wire logic [3:0]        tap_i,
	output logic                   tick_o
);
	import wdit_pkg::*;

	logic [WIDTH-1:0] div_ff;
	logic [WIDTH-1:0] prev_ff;

	// One divider feeds every tap, so all eight rates share phase
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			div_ff  <= '0;
			prev_ff <= '0;
		end
		else
		begin
			div_ff  <= div_ff + 1'b1;
			prev_ff <= div_ff;
		end
	end

	// Tick on the falling edge of the chosen divider bit: one pulse per period
	always_comb
	begin
		tick_o = prev_ff[tap_i] & ~div_ff[tap_i];
	end
endmodule

// File: logic/wdit_timer.sv
// Supervisory timer: keyed registers, 8-bit counter, interval and watchdog overflow handling
`timescale 1ns/1ps
module wdit_timer
(
	// Clock and reset
	input  wire logic                 core_clk_i,
	input  wire logic                 rst_i,
	input  wire logic                 standby_i,
	// CPU bus
	input  wire logic [31:0]          bus_addr_i,
	input  wire logic                 bus_wr_i,
	input  wire logic                 bus_rd_i,
	input  wire logic [1:0]           bus_size_i,
	input  wire logic [15:0]          bus_wdata_i,
	output logic      [7:0]           bus_rdata_o,
	// Events
	output logic                      interval_interrupt_o,
	output logic                      internal_reset_o
);
	import wdit_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [7:0]       count_ff;
	logic             ovf_ff;
	logic             mode_ff;
	logic             enable_ff;
	logic [2:0]       cks_ff;
	logic             watchdog_overflow_flag_ff;
	logic             rsten_ff;
	logic             rstsel_ff;
	logic             ovf_seen_ff;
	logic             watchdog_overflow_flag_seen_ff;
	logic [9:0]       rst_cnt_ff;
	wdit_rst_state_t  rst_state_ff;
	logic [7:0]       rdata_ff;
	logic             iti_ff;
	logic             tick;
	logic [3:0]       tap;
	logic             wrap;
	logic             word_wr;
	logic             wr_count;
	logic             wr_ctrl;
	logic             wr_rst_clr;
	logic             wr_rst_set;
	logic             byte_rd;
	logic [7:0]       ctrl_view;
	logic [7:0]       rst_view;

	// ----------------------------------------
	// Prescaler and decode
	// ----------------------------------------
	// Tap choice per clock-select code
	always_comb
	begin
		case (cks_ff)
			3'h0: tap = WDIT_TAP0;
			3'h1: tap = WDIT_TAP1;
			3'h2: tap = WDIT_TAP2;
			3'h3: tap = WDIT_TAP3;
			3'h4: tap = WDIT_TAP4;
			3'h5: tap = WDIT_TAP5;
			3'h6: tap = WDIT_TAP6;
			3'h7: tap = WDIT_TAP7;
			default: tap = WDIT_TAP0;
		endcase
	end

	wdit_prescaler #(.WIDTH(WDIT_PRESCALE_W)) u_prescaler
	(
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.tap_i      (tap),
		.tick_o     (tick)
	);

	// Keyed word writes; byte and long writes fall through untouched
	assign word_wr    = bus_wr_i && (bus_size_i == WDIT_SIZE_WORD);
	assign wr_count   = word_wr && bus_addr_i == WDIT_CTRL_ADDR && bus_wdata_i[15:8] == WDIT_KEY_COUNT;
	assign wr_ctrl    = word_wr && bus_addr_i == WDIT_CTRL_ADDR && bus_wdata_i[15:8] == WDIT_KEY_CTRL;
	assign wr_rst_clr = word_wr && bus_addr_i == WDIT_RSTCTL_WADDR && bus_wdata_i == {WDIT_KEY_CTRL, 8'h00};
	assign wr_rst_set = word_wr && bus_addr_i == WDIT_RSTCTL_WADDR && bus_wdata_i[15:8] == WDIT_KEY_COUNT;
	assign byte_rd    = bus_rd_i && (bus_size_i == WDIT_SIZE_BYTE);
	// Overflow only counts when the write does not win the same cycle
	assign wrap       = enable_ff && tick && !wr_count && count_ff == 8'hff;
	assign ctrl_view  = {ovf_ff, mode_ff, enable_ff, 2'b11, cks_ff} | WDIT_CTRL_ONES;
	assign rst_view   = {watchdog_overflow_flag_ff, rsten_ff, 1'b0, 5'h00} | WDIT_RSTCTL_ONES;

	// ----------------------------------------
	// Counter
	// ----------------------------------------
	// A write beats an increment landing in the same cycle
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i || !enable_ff)
			count_ff <= WDIT_COUNT_RESET;
		else if (wr_count)
			count_ff <= bus_wdata_i[7:0];
		else if (tick)
			count_ff <= count_ff + 8'h01;
	end

	// ----------------------------------------
	// Control register
	// ----------------------------------------
	// Standby clears the top three bits; the clock select survives it
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			mode_ff   <= 1'b0;
			enable_ff <= 1'b0;
			cks_ff    <= 3'h0;
		end
		else if (standby_i)
		begin
			mode_ff   <= 1'b0;
			enable_ff <= 1'b0;
		end
		else if (wr_ctrl)
		begin
			mode_ff   <= bus_wdata_i[WDIT_MODE_BIT];
			enable_ff <= bus_wdata_i[WDIT_ENABLE_BIT];
			cks_ff    <= bus_wdata_i[2:0];
		end
	end

	// Interval flag: set wins over a clear in the same cycle
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i || standby_i)
		begin
			ovf_ff      <= 1'b0;
			ovf_seen_ff <= 1'b0;
		end
		else
		begin
			if (wrap && !mode_ff)
				ovf_ff <= 1'b1;
			else if (wr_ctrl && !bus_wdata_i[WDIT_FLAG_BIT] && ovf_seen_ff)
				ovf_ff <= 1'b0;
			if (byte_rd && bus_addr_i == WDIT_CTRL_ADDR && ovf_ff)
				ovf_seen_ff <= 1'b1;
			else if (wr_ctrl)
				ovf_seen_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// Reset-control register
	// ----------------------------------------
	// Internal reset does not touch this register, only the external one does
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			watchdog_overflow_flag_ff      <= 1'b0;
			watchdog_overflow_flag_seen_ff <= 1'b0;
			rsten_ff     <= 1'b0;
			rstsel_ff    <= 1'b0;
		end
		else
		begin
			if (wrap && mode_ff)
				watchdog_overflow_flag_ff <= 1'b1;
			else if (wr_rst_clr && watchdog_overflow_flag_seen_ff)
				watchdog_overflow_flag_ff <= 1'b0;
			if (byte_rd && bus_addr_i == WDIT_RSTCTL_RADDR && watchdog_overflow_flag_ff)
				watchdog_overflow_flag_seen_ff <= 1'b1;
			else if (wr_rst_clr)
				watchdog_overflow_flag_seen_ff <= 1'b0;
			if (wr_rst_set)
			begin
				rsten_ff  <= bus_wdata_i[WDIT_RSTEN_BIT];
				rstsel_ff <= bus_wdata_i[WDIT_RSTSEL_BIT];
			end
		end
	end

	// ----------------------------------------
	// Internal reset pulse and interval interrupt
	// ----------------------------------------
	// Fixed-length reset pulse; a new overflow meanwhile is absorbed
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			rst_state_ff <= WDIT_RST_IDLE;
			rst_cnt_ff   <= '0;
		end
		else
		begin
			case (rst_state_ff)
				WDIT_RST_IDLE:
					if (wrap && mode_ff && rsten_ff)
					begin
						rst_state_ff <= WDIT_RST_PULSE;
						rst_cnt_ff   <= 10'(WDIT_RST_CYCLES - 1);
					end
				WDIT_RST_PULSE:
					if (rst_cnt_ff == 10'h000)
						rst_state_ff <= WDIT_RST_IDLE;
					else
						rst_cnt_ff <= rst_cnt_ff - 10'h001;
				default:
					rst_state_ff <= WDIT_RST_IDLE;
			endcase
		end
	end

	assign internal_reset_o = (rst_state_ff == WDIT_RST_PULSE);

	// Interval interrupt is a one-cycle pulse per overflow in interval mode
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
			iti_ff <= 1'b0;
		else
			iti_ff <= wrap && !mode_ff;
	end

	assign interval_interrupt_o = iti_ff;

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// Word and long reads, and unmapped bytes, return zero
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
			rdata_ff <= 8'h00;
		else if (!byte_rd)
			rdata_ff <= 8'h00;
		else if (bus_addr_i == WDIT_CTRL_ADDR)
			rdata_ff <= ctrl_view;
		else if (bus_addr_i == WDIT_COUNT_ADDR)
			rdata_ff <= count_ff;
		else if (bus_addr_i == WDIT_RSTCTL_RADDR)
			rdata_ff <= rst_view;
		else
			rdata_ff <= 8'h00;
	end

	assign bus_rdata_o = rdata_ff;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_disabled_count_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!$past(enable_ff) |-> count_ff == 8'h00) else $error("count not zero while disabled");
	// Helper count of consecutive high cycles of the internal reset; a counter keeps the check cheap
	logic [9:0]       rst_len_ff;

	always_ff @(posedge core_clk_i)
	begin
		if (rst_i || !internal_reset_o)
			rst_len_ff <= 10'h000;
		else
			rst_len_ff <= rst_len_ff + 10'h001;
	end

	chk_reset_pulse_len: assert property (@(posedge core_clk_i) disable iff (rst_i)
		$fell(internal_reset_o) |-> rst_len_ff == 10'(WDIT_RST_CYCLES)) else $error("reset pulse length wrong");
	chk_reset_pulse_max: assert property (@(posedge core_clk_i) disable iff (rst_i)
		internal_reset_o |-> rst_len_ff < 10'(WDIT_RST_CYCLES)) else $error("reset pulse too long");
	chk_iti_mode: assert property (@(posedge core_clk_i) disable iff (rst_i)
		wrap && !mode_ff |=> interval_interrupt_o && ovf_ff) else $error("interval overflow missed");
	chk_watchdog_overflow_flag_mode: assert property (@(posedge core_clk_i) disable iff (rst_i)
		wrap && mode_ff |=> watchdog_overflow_flag_ff && !interval_interrupt_o) else $error("watchdog flag missed");
	chk_ovf_only_interval: assert property (@(posedge core_clk_i) disable iff (rst_i)
		$rose(ovf_ff) |-> $past(!mode_ff)) else $error("interval flag set in watchdog mode");
	chk_ovf_clear_seq: assert property (@(posedge core_clk_i) disable iff (rst_i || standby_i)
		$fell(ovf_ff) |-> $past(wr_ctrl) && $past(ovf_seen_ff)) else $error("flag cleared without read");
	chk_byte_write_ignored: assert property (@(posedge core_clk_i) disable iff (rst_i || standby_i)
		bus_wr_i && bus_size_i != WDIT_SIZE_WORD && !enable_ff |=> $stable(cks_ff)) else $error("non-word write taken");
	chk_ctrl_ones: assert property (@(posedge core_clk_i) disable iff (rst_i)
		byte_rd && bus_addr_i == WDIT_CTRL_ADDR |=> bus_rdata_o[4:3] == 2'b11) else $error("bits 4,3 not one");
endmodule

// File: testbench/testbench.sv
// Self-checking bench of the supervisory timer: registers, interval, watchdog and standby
`timescale 1ns/1ps
module testbench;
	import wdit_pkg::*;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        core_clk_i  = 1'b0;
	logic        rst_i       = 1'b1;
	logic        standby_i   = 1'b0;
	logic [31:0] bus_addr_i  = 32'h0;
	logic        bus_wr_i    = 1'b0;
	logic        bus_rd_i    = 1'b0;
	logic [1:0]  bus_size_i  = 2'h0;
	logic [15:0] bus_wdata_i = 16'h0;
	logic [7:0]  bus_rdata_o;
	logic        interval_interrupt_o;
	logic        internal_reset_o;
	int          err_count   = 0;
	int          n_checks    = 0;
	int          cyc         = 0;
	logic [31:0] t0;
	logic [31:0] t1;
	logic [7:0]  r;
	logic [7:0]  q;

	// Clock and free cycle stamp for interval measurements
	always #2.5 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i) cyc <= cyc + 1;

	wdit_timer i_wdit_timer
	(
		.core_clk_i           (core_clk_i),
		.rst_i                (rst_i),
		.standby_i            (standby_i),
		.bus_addr_i           (bus_addr_i),
		.bus_wr_i             (bus_wr_i),
		.bus_rd_i             (bus_rd_i),
		.bus_size_i           (bus_size_i),
		.bus_wdata_i          (bus_wdata_i),
		.bus_rdata_o          (bus_rdata_o),
		.interval_interrupt_o (interval_interrupt_o),
		.internal_reset_o     (internal_reset_o)
	);

	// ----------------------------------------
	// Expectations
	// ----------------------------------------
	// Flag never comes from a write; bits 4 and 3 always read one
	function logic [7:0] ctrl_exp(input logic [7:0] d);
		return {1'b0, d[6:5], 2'b11, d[2:0]};
	endfunction

	function logic [31:0] div_of(input logic [2:0] c);
		case (c)
			3'h0: return 32'd2;
			3'h1: return 32'd64;
			3'h2: return 32'd128;
			3'h3: return 32'd256;
			3'h4: return 32'd512;
			3'h5: return 32'd1024;
			3'h6: return 32'd4096;
			default: return 32'd8192;
		endcase
	endfunction

	// ----------------------------------------
	// Bus tasks and checks
	// ----------------------------------------
	task close_out();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			err_count++;
		end
	endtask

	// One strobe cycle; the next call lets an edge pass with the strobe low
	task wr(input logic [31:0] a, input logic [1:0] s, input logic [15:0] d);
		@(posedge core_clk_i);
		bus_addr_i  <= a;
		bus_size_i  <= s;
		bus_wdata_i <= d;
		bus_wr_i    <= 1'b1;
		@(posedge core_clk_i);
		bus_wr_i    <= 1'b0;
	endtask

	task rchk(input logic [31:0] a, input logic [1:0] s, input logic [7:0] exp);
		@(posedge core_clk_i);
		bus_addr_i <= a;
		bus_size_i <= s;
		bus_rd_i   <= 1'b1;
		@(posedge core_clk_i);
		bus_rd_i   <= 1'b0;
		#1 q = bus_rdata_o;
		chk(q, exp);
	endtask

	// Bounded wait for an output level; stamp taken where outputs have settled
	task wait_sig(input bit rst_sel, input bit lvl, input int bound, output logic [31:0] st);
		int i;
		i = 0;
		#1;
		while (i < bound && ((rst_sel ? internal_reset_o : interval_interrupt_o) !== lvl))
		begin
			@(posedge core_clk_i);
			#1 i++;
		end
		st = cyc;
		if (i >= bound)
		begin
			$display("ERROR t=%0t got=%h exp=%h", $time, i, bound);
			err_count++;
			close_out();
		end
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		void'($urandom(32'hb7d9));
		repeat (10) @(posedge core_clk_i);
		rst_i <= 1'b0;
		rchk(WDIT_CTRL_ADDR, WDIT_SIZE_BYTE, 8'h18);
		rchk(WDIT_COUNT_ADDR, WDIT_SIZE_BYTE, 8'h00);
		rchk(WDIT_RSTCTL_RADDR, WDIT_SIZE_BYTE, 8'h1f);
		rchk(WDIT_CTRL_ADDR, WDIT_SIZE_WORD, 8'h00);
		rchk(WDIT_COUNT_ADDR, WDIT_SIZE_LONG, 8'h00);
		rchk(32'hffff8614, WDIT_SIZE_BYTE, 8'h00);
		$display("test reset done");
		// Random control values with the timer kept off
		repeat (8)
		begin
			r = 8'($urandom) & 8'hdf;
			wr(WDIT_CTRL_ADDR, WDIT_SIZE_WORD, {WDIT_KEY_CTRL, r});
			rchk(WDIT_CTRL_ADDR, WDIT_SIZE_BYTE, ctrl_exp(r));
		end
		$display("test control done");
		// Slowest clock so a tick rarely lands between write and read
		wr(WDIT_CTRL_ADDR, WDIT_SIZE_WORD, {WDIT_KEY_CTRL, 8'h27});
		repeat (6)
		begin
			r = 8'($urandom);
			wr(WDIT_CTRL_ADDR, WDIT_SIZE_WORD, {WDIT_KEY_COUNT, r});
			wr(WDIT_CTRL_ADDR, WDIT_SIZE_BYTE, {WDIT_KEY_COUNT, ~r});
			wr(WDIT_CTRL_ADDR, WDIT_SIZE_LONG, {WDIT_KEY_COUNT, ~r});
			wr(WDIT_CTRL_ADDR, WDIT_SIZE_WORD, {8'h12, ~r});
			rchk(WDIT_COUNT_ADDR, WDIT_SIZE_BYTE, r);
		end
		wr(WDIT_CTRL_ADDR, WDIT_SIZE_WORD, {WDIT_KEY_CTRL, 8'h07});
		rchk(WDIT_COUNT_ADDR, WDIT_SIZE_BYTE, 8'h00);
		$display("test count done");
		// Interval between two overflows from a count of ff is one division
		for (int c = 1; c < 8; c++)
		begin
			wr(WDIT_CTRL_ADDR, WDIT_SIZE_WORD, {WDIT_KEY_CTRL, 5'h04, 3'(c)});
			wr(WDIT_CTRL_ADDR, WDIT_SIZE_WORD, {WDIT_KEY_COUNT, 8'hff});
			wait_sig(1'b0, 1'b1, 2 * div_of(3'(c)) + 20, t0);
			wr(WDIT_CTRL_ADDR, WDIT_SIZE_WORD, {WDIT_KEY_COUNT, 8'hff});
			wait_sig(1'b0, 1'b1, div_of(3'(c)) + 20, t1);
			chk(t1 - t0, div_of(3'(c)));
			wr(WDIT_CTRL_ADDR, WDIT_SIZE_WORD, {WDIT_KEY_CTRL, 8'h00});
		end
		wr(WDIT_CTRL_ADDR, WDIT_SIZE_WORD, {WDIT_KEY_CTRL, 8'h20});
		wr(WDIT_CTRL_ADDR, WDIT_SIZE_WORD, {WDIT_KEY_COUNT, 8'hff});
		wait_sig(1'b0, 1'b1, 20, t0);
		$display("test interval done");
		// Clearing without a prior read of one must not take effect
		wr(WDIT_CTRL_ADDR, WDIT_SIZE_WORD, {WDIT_KEY_CTRL, 8'h00});
		rchk(WDIT_CTRL_ADDR, WDIT_SIZE_BYTE, 8'h98);
		wr(WDIT_CTRL_ADDR, WDIT_SIZE_WORD, {WDIT_KEY_CTRL, 8'h80});
		rchk(WDIT_CTRL_ADDR, WDIT_SIZE_BYTE, 8'h98);
		wr(WDIT_CTRL_ADDR, WDIT_SIZE_WORD, {WDIT_KEY_CTRL, 8'h00});
		rchk(WDIT_CTRL_ADDR, WDIT_SIZE_BYTE, 8'h18);
		rchk(WDIT_RSTCTL_RADDR, WDIT_SIZE_BYTE, 8'h1f);
		$display("test flag done");
		// Watchdog overflow; timer stopped at once so no second overflow starts a new pulse
		wr(WDIT_RSTCTL_WADDR, WDIT_SIZE_WORD, {WDIT_KEY_COUNT, 8'h40});
		rchk(WDIT_RSTCTL_RADDR, WDIT_SIZE_BYTE, 8'h5f);
		wr(WDIT_CTRL_ADDR, WDIT_SIZE_WORD, {WDIT_KEY_CTRL, 8'h60});
		wr(WDIT_CTRL_ADDR, WDIT_SIZE_WORD, {WDIT_KEY_COUNT, 8'hff});
		wait_sig(1'b1, 1'b1, 20, t0);
		wr(WDIT_CTRL_ADDR, WDIT_SIZE_WORD, {WDIT_KEY_CTRL, 8'h40});
		wait_sig(1'b1, 1'b0, 600, t1);
		chk(t1 - t0, WDIT_RST_CYCLES);
		rchk(WDIT_CTRL_ADDR, WDIT_SIZE_BYTE, 8'h58);
		rchk(WDIT_RSTCTL_RADDR, WDIT_SIZE_BYTE, 8'hdf);
		wr(WDIT_RSTCTL_WADDR, WDIT_SIZE_WORD, {WDIT_KEY_CTRL, 8'h00});
		rchk(WDIT_RSTCTL_RADDR, WDIT_SIZE_BYTE, 8'h5f);
		// Watchdog overflow with reset disabled: flag only, no internal reset
		wr(WDIT_RSTCTL_WADDR, WDIT_SIZE_WORD, {WDIT_KEY_COUNT, 8'h00});
		wr(WDIT_CTRL_ADDR, WDIT_SIZE_WORD, {WDIT_KEY_CTRL, 8'h60});
		wr(WDIT_CTRL_ADDR, WDIT_SIZE_WORD, {WDIT_KEY_COUNT, 8'hff});
		wr(WDIT_CTRL_ADDR, WDIT_SIZE_WORD, {WDIT_KEY_CTRL, 8'h40});
		rchk(WDIT_RSTCTL_RADDR, WDIT_SIZE_BYTE, 8'h9f);
		chk(internal_reset_o, 32'h0);
		// Setting the reset-enable bit leaves a pending flag alone
		wr(WDIT_RSTCTL_WADDR, WDIT_SIZE_WORD, {WDIT_KEY_COUNT, 8'h40});
		rchk(WDIT_RSTCTL_RADDR, WDIT_SIZE_BYTE, 8'hdf);
		$display("test watchdog done");
		// Standby clears bits 7 to 5 only
		wr(WDIT_CTRL_ADDR, WDIT_SIZE_WORD, {WDIT_KEY_CTRL, 8'h25});
		@(posedge core_clk_i);
		standby_i <= 1'b1;
		repeat (3) @(posedge core_clk_i);
		standby_i <= 1'b0;
		rchk(WDIT_CTRL_ADDR, WDIT_SIZE_BYTE, ctrl_exp(8'h05));
		rchk(WDIT_COUNT_ADDR, WDIT_SIZE_BYTE, 8'h00);
		$display("test standby done");
		close_out();
	end
endmodule
